//--- verilog/urxs_pkg.sv
// Constants, types and state records of the serial receive status block.
// Assumes a 10 MHz clock and a synchronous active-high reset.
package urxs_pkg;

    // Bit timing: cycles per serial bit at the fixed line rate
    localparam int         CLK_HZ     = 10_000_000;
    localparam int         BAUD_HZ    = 115_200;
    localparam int         BIT_CYCLES = CLK_HZ / BAUD_HZ;
    localparam logic [7:0] BIT_LAST   = 8'(BIT_CYCLES - 1);
    localparam logic [7:0] HALF_LAST  = 8'(BIT_CYCLES / 2 - 1);

    // Register byte offsets on the bus
    localparam logic [7:0] OFS_STATUS   = 8'h00;
    localparam logic [7:0] OFS_RXDATA   = 8'h04;
    localparam logic [7:0] OFS_CONFIG   = 8'h08;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h10;

    // Field positions in the status/control register
    localparam int BIT_ADDRESS_DETECT_ENABLE = 5;
    localparam int BIT_IDLE  = 4;
    localparam int BIT_PARITY_ERROR_FLAG  = 3;
    localparam int BIT_FRAMING_ERROR_FLAG  = 2;
    localparam int BIT_RECEIVE_OVERRUN_FLAG  = 1;
    localparam int BIT_AVAIL = 0;

    // Interrupt status / mask bit positions
    localparam int IRQ_W      = 4;
    localparam int IRQ_RXCHAR = 0;
    localparam int IRQ_RECEIVE_OVERRUN_FLAG   = 1;
    localparam int IRQ_PARITY_ERROR_FLAG   = 2;
    localparam int IRQ_FRAMING_ERROR_FLAG   = 3;

    // Character formats
    typedef enum logic [1:0] {
        URXS_MODE_8N = 2'b00,
        URXS_MODE_8E = 2'b01,
        URXS_MODE_8O = 2'b10,
        URXS_MODE_9N = 2'b11
    } urxs_mode_t;

    // Receiver sequence
    typedef enum logic [2:0] {
        URXS_IDLE   = 3'b000,
        URXS_START  = 3'b001,
        URXS_DATA   = 3'b010,
        URXS_PARITY = 3'b011,
        URXS_STOP   = 3'b100
    } urxs_fsm_t;

    // Values after reset
    localparam urxs_mode_t       RST_MODE  = URXS_MODE_8N;
    localparam logic             RST_ADDRESS_DETECT_ENABLE = 1'b0;
    localparam logic [IRQ_W-1:0] RST_MASK  = 4'h0;
    localparam logic [2:0]       RST_LINE  = 3'h7;

    // Receive FIFO geometry
    localparam int         FIFO_DEPTH = 4;
    localparam int         FIFO_PTR_W = 2;
    localparam logic [2:0] FIFO_FULL  = 3'h4;

    typedef struct packed {
        logic       framing_error_flag;
        logic       parity_error_flag;
        logic [8:0] data;
    } urxs_entry_t;

    typedef struct packed {
        urxs_entry_t [FIFO_DEPTH-1:0] mem;
        logic [FIFO_PTR_W-1:0]        wptr;
        logic [FIFO_PTR_W-1:0]        rptr;
        logic [2:0]                   count;
    } urxs_fifo_t;

    typedef struct packed {
        logic [2:0] ff;
        logic       level;
    } urxs_sync_t;

    typedef struct packed {
        urxs_fsm_t        fsm;
        logic [7:0]       cnt;
        logic [3:0]       bitidx;
        logic [8:0]       shift;
        logic             parity_error_flag;
        logic             addr_en;
        urxs_mode_t       mode;
        logic             receive_overrun_flag;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic             ack;
        logic [31:0]      rdata;
    } urxs_state_t;

endpackage : urxs_pkg

//--- verilog/urxs_sync.sv
// Three-stage synchroniser and agreement filter for the receive pin.
// Assumes the pin idles high and is asynchronous to clk_i.
`timescale 1ns/10ps
module urxs_sync
    import urxs_pkg::*;
(
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Pin and filtered level
    input  wire logic pin_i,
    output logic      level_o
);

    urxs_sync_t r_reg;
    urxs_sync_t r_next;

    // Level only moves when stages two and three agree
    always_comb begin
        r_next    = r_reg;
        r_next.ff = {r_reg.ff[1:0], pin_i};
        if (r_reg.ff[1] == r_reg.ff[2]) begin
            r_next.level = r_reg.ff[2];
        end
    end

    // Line reads idle (high) out of reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r_reg.ff    <= RST_LINE;
            r_reg.level <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign level_o = r_reg.level;

endmodule : urxs_sync

//--- verilog/urxs_fifo.sv
// Receive character FIFO with per-entry error flags and flush.
// Assumes the writer never pushes while full.
`timescale 1ns/10ps
module urxs_fifo
    import urxs_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Control
    input  wire logic        push_i,
    input  wire urxs_entry_t push_data_i,
    input  wire logic        pop_i,
    input  wire logic        flush_i,
    // Head and fill state
    output urxs_entry_t      head_o,
    output logic             empty_o,
    output logic             full_o
);

    urxs_fifo_t r_reg;
    urxs_fifo_t r_next;
    logic       do_push;
    logic       do_pop;

    // Pointer and count update; flush overrides both sides
    always_comb begin
        r_next  = r_reg;
        do_push = push_i && (r_reg.count != FIFO_FULL);
        do_pop  = pop_i && (r_reg.count != 3'h0);
        if (do_push) begin
            r_next.mem[r_reg.wptr] = push_data_i;
            r_next.wptr = r_reg.wptr + 2'h1;
        end
        if (do_pop) begin
            r_next.rptr = r_reg.rptr + 2'h1;
        end
        r_next.count = r_reg.count + 3'(do_push) - 3'(do_pop);
        if (flush_i) begin
            r_next.wptr  = '0;
            r_next.rptr  = '0;
            r_next.count = '0;
        end
    end

    // Storage is cleared too so the head shows no flags before the first push
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign head_o  = r_reg.mem[r_reg.rptr];
    assign empty_o = (r_reg.count == 3'h0);
    assign full_o  = (r_reg.count == FIFO_FULL);

endmodule : urxs_fifo

//--- verilog/urxs_top.sv
// Receive side of an asynchronous serial port: deserialiser, receive
// FIFO, status/control register, address detect and interrupt logic.
// Assumes a classic Wishbone master and an idle-high receive line.
// Overview of operation
// - Address detect is active only when its enable bit is set and the 9-bit format is selected.
// - In address detect, only characters whose ninth bit is one are kept as address characters.
// - The idle status bit reads one while no character is being received and zero during one.
// - The parity error bit shows the parity error of the character at the FIFO head.
// - The framing error bit shows the framing error of the character at the FIFO head.
// - Overrun is set by hardware when a character arrives with the FIFO full; software can only clear it.
// - Clearing a set overrun bit empties the FIFO and resets the receive shift register.
// - The data available bit reads one while the FIFO holds at least one character.
`timescale 1ns/10ps
module urxs_top
    import urxs_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Serial line and interrupt
    input  wire logic        rxd_i,
    output logic             irq_o
);

    urxs_state_t      r_reg;
    urxs_state_t      r_next;
    logic             rxd;
    urxs_entry_t      head;
    urxs_entry_t      push_data;
    logic             fifo_empty;
    logic             fifo_full;
    logic             push;
    logic             pop;
    logic             flush;
    logic             done;
    logic             addr_mode;
    logic             ovr_set;
    logic             req;
    logic             acc;
    logic             nine;
    logic [8:0]       data9;
    logic [3:0]       last_bit;
    logic [15:0]      status_val;
    logic [IRQ_W-1:0] ev;

    urxs_sync u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (rxd_i),
        .level_o (rxd)
    );

    urxs_fifo u_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .push_i      (push),
        .push_data_i (push_data),
        .pop_i       (pop),
        .flush_i     (flush),
        .head_o      (head),
        .empty_o     (fifo_empty),
        .full_o      (fifo_full)
    );

    // Status word; head flags read zero when there is no head
    always_comb begin
        status_val            = 16'h0000;
        status_val[BIT_ADDRESS_DETECT_ENABLE] = r_reg.addr_en;
        status_val[BIT_IDLE]  = (r_reg.fsm == URXS_IDLE);
        status_val[BIT_PARITY_ERROR_FLAG]  = head.parity_error_flag && !fifo_empty;
        status_val[BIT_FRAMING_ERROR_FLAG]  = head.framing_error_flag && !fifo_empty;
        status_val[BIT_RECEIVE_OVERRUN_FLAG]  = r_reg.receive_overrun_flag;
        status_val[BIT_AVAIL] = !fifo_empty;
    end

    // Receiver, register access and interrupt state
    always_comb begin
        r_next    = r_reg;
        push      = 1'b0;
        pop       = 1'b0;
        flush     = 1'b0;
        done      = 1'b0;
        ovr_set   = 1'b0;
        ev        = '0;
        req       = wb_cyc_i && wb_stb_i;
        acc       = req && r_reg.ack;
        nine      = (r_reg.mode == URXS_MODE_9N);
        addr_mode = r_reg.addr_en && nine;
        last_bit  = nine ? 4'h8 : 4'h7;
        // 8-bit characters end up in the top eight shift bits
        data9     = nine ? r_reg.shift : {1'b0, r_reg.shift[8:1]};
        push_data = '{framing_error_flag: !rxd, parity_error_flag: r_reg.parity_error_flag, data: data9};

        unique case (r_reg.fsm)
            URXS_IDLE: begin
                if (!rxd) begin
                    r_next.fsm = URXS_START;
                    r_next.cnt = HALF_LAST;
                end
            end
            URXS_START: begin
                if (r_reg.cnt != 8'h00) begin
                    r_next.cnt = r_reg.cnt - 8'h01;
                end else if (rxd) begin
                    r_next.fsm = URXS_IDLE; // Glitch, not a start bit
                end else begin
                    r_next.fsm    = URXS_DATA;
                    r_next.cnt    = BIT_LAST;
                    r_next.bitidx = 4'h0;
                    r_next.parity_error_flag   = 1'b0;
                end
            end
            URXS_DATA: begin
                if (r_reg.cnt != 8'h00) begin
                    r_next.cnt = r_reg.cnt - 8'h01;
                end else begin
                    r_next.cnt    = BIT_LAST;
                    r_next.shift  = {rxd, r_reg.shift[8:1]};
                    r_next.bitidx = r_reg.bitidx + 4'h1;
                    if (r_reg.bitidx == last_bit) begin
                        r_next.fsm = (r_reg.mode == URXS_MODE_8E ||
                                      r_reg.mode == URXS_MODE_8O)
                                   ? URXS_PARITY : URXS_STOP;
                    end
                end
            end
            URXS_PARITY: begin
                if (r_reg.cnt != 8'h00) begin
                    r_next.cnt = r_reg.cnt - 8'h01;
                end else begin
                    r_next.cnt  = BIT_LAST;
                    r_next.fsm  = URXS_STOP;
                    r_next.parity_error_flag = (^data9) ^ rxd ^
                                  (r_reg.mode == URXS_MODE_8O);
                end
            end
            URXS_STOP: begin
                if (r_reg.cnt != 8'h00) begin
                    r_next.cnt = r_reg.cnt - 8'h01;
                end else begin
                    // Low stop bit is a framing error; the line may
                    // already carry the next start bit
                    done       = 1'b1;
                    r_next.fsm = URXS_IDLE;
                end
            end
            default: begin
                r_next.fsm = URXS_IDLE;
            end
        endcase

        // Completed character: drop, flag overrun or store
        if (done) begin
            if (r_reg.receive_overrun_flag) begin
                push = 1'b0;
            end else if (addr_mode && !data9[8]) begin
                push = 1'b0;
            end else if (fifo_full) begin
                ovr_set = 1'b1;
            end else begin
                push = 1'b1;
            end
        end

        // Bus: read data latched on the first cycle, effects at ack
        r_next.ack = req && !r_reg.ack;
        if (req && !r_reg.ack && !wb_we_i) begin
            unique case (wb_adr_i)
                OFS_STATUS:   r_next.rdata = 32'(status_val);
                // Empty buffer reads zero, never a stale character
                OFS_RXDATA:   r_next.rdata = fifo_empty ? 32'h0000_0000
                                                        : 32'(head.data);
                OFS_CONFIG:   r_next.rdata = 32'(r_reg.mode);
                OFS_IRQ_STAT: r_next.rdata = 32'(r_reg.irq_stat);
                OFS_IRQ_MASK: r_next.rdata = 32'(r_reg.irq_mask);
                default:      r_next.rdata = 32'h0000_0000;
            endcase
        end
        if (acc && wb_we_i && wb_sel_i[0]) begin
            unique case (wb_adr_i)
                OFS_STATUS: begin
                    r_next.addr_en = wb_dat_i[BIT_ADDRESS_DETECT_ENABLE];
                    // Only a one-to-zero write acts; a one is ignored
                    if (r_reg.receive_overrun_flag && !wb_dat_i[BIT_RECEIVE_OVERRUN_FLAG]) begin
                        r_next.receive_overrun_flag = 1'b0;
                        flush       = 1'b1;
                    end
                end
                OFS_CONFIG:   r_next.mode = urxs_mode_t'(wb_dat_i[1:0]);
                OFS_IRQ_MASK: r_next.irq_mask = wb_dat_i[IRQ_W-1:0];
                default:      r_next.mode = r_reg.mode;
            endcase
        end
        if (acc && !wb_we_i && wb_adr_i == OFS_RXDATA) begin
            pop = 1'b1;
        end
        if (acc && !wb_we_i && wb_adr_i == OFS_IRQ_STAT) begin
            r_next.irq_stat = '0;
        end

        // Events set sticky bits after any clear, so the set wins
        ev[IRQ_RXCHAR]  = push;
        ev[IRQ_RECEIVE_OVERRUN_FLAG]    = ovr_set;
        ev[IRQ_PARITY_ERROR_FLAG]    = push && push_data.parity_error_flag;
        ev[IRQ_FRAMING_ERROR_FLAG]    = push && push_data.framing_error_flag;
        r_next.irq_stat = r_next.irq_stat | ev;
        if (ovr_set) begin
            r_next.receive_overrun_flag = 1'b1;
        end

        // Flush aborts any frame in progress
        if (flush) begin
            r_next.fsm    = URXS_IDLE;
            r_next.shift  = 9'h000;
            r_next.cnt    = 8'h00;
            r_next.bitidx = 4'h0;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r_reg          <= '0;
            r_reg.fsm      <= URXS_IDLE;
            r_reg.addr_en  <= RST_ADDRESS_DETECT_ENABLE;
            r_reg.mode     <= RST_MODE;
            r_reg.irq_mask <= RST_MASK;
        end else begin
            r_reg <= r_next;
        end
    end

    // Outputs
    assign wb_dat_o = r_reg.rdata;
    assign wb_ack_o = r_reg.ack;
    assign irq_o    = |(r_reg.irq_stat & r_reg.irq_mask);

    // Checks
    addr_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        done && r_reg.addr_en && !nine && !r_reg.receive_overrun_flag && !fifo_full
        |-> push)
        else $error("address detect acted outside 9-bit mode");
    addr_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
        done && addr_mode && !data9[8] |-> !push)
        else $error("data character kept during address detect");
    idle_busy_a: assert property (@(posedge clk_i) disable iff (rst_i)
        r_reg.fsm == URXS_IDLE && !rxd && !flush |=> !status_val[BIT_IDLE])
        else $error("idle bit stayed high after start edge");
    head_parity_error_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        push && fifo_empty && !pop && !flush
        |=> status_val[BIT_PARITY_ERROR_FLAG] == $past(r_reg.parity_error_flag))
        else $error("parity flag does not follow head character");
    head_framing_error_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        push && fifo_empty && !pop && !flush
        |=> status_val[BIT_FRAMING_ERROR_FLAG] != $past(rxd))
        else $error("framing flag does not follow head character");
    ovr_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        done && fifo_full && !r_reg.receive_overrun_flag && !(addr_mode && !data9[8])
        |=> r_reg.receive_overrun_flag && r_reg.irq_stat[IRQ_RECEIVE_OVERRUN_FLAG])
        else $error("overrun not flagged on full buffer");
    ovr_nosw_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !r_reg.receive_overrun_flag && !ovr_set |=> !r_reg.receive_overrun_flag)
        else $error("overrun bit set without overflow");
    ovr_flush_a: assert property (@(posedge clk_i) disable iff (rst_i)
        flush |=> fifo_empty && r_reg.fsm == URXS_IDLE && !r_reg.receive_overrun_flag)
        else $error("overrun clear did not empty receiver");
    avail_push_a: assert property (@(posedge clk_i) disable iff (rst_i)
        push && !flush |=> status_val[BIT_AVAIL] [*1] ##0 !fifo_empty)
        else $error("data available low after store");
    ovr_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
        r_reg.receive_overrun_flag && done && !pop && !flush
        |-> !push ##1 $stable(fifo_empty))
        else $error("character stored while overrun set");

    // Further receive, bus and interrupt checks
    addr_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
        done && addr_mode && data9[8] && !r_reg.receive_overrun_flag && !fifo_full |-> push)
        else $error("address character not stored");
    idle_back_a: assert property (@(posedge clk_i) disable iff (rst_i)
        done |=> status_val[BIT_IDLE])
        else $error("idle bit low after stop bit");
    ovr_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        r_reg.receive_overrun_flag && !flush |=> r_reg.receive_overrun_flag)
        else $error("overrun bit dropped without a clear");
    avail_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
        fifo_empty && !push |=> !status_val[BIT_AVAIL])
        else $error("data available high with empty buffer");
    irq_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        acc && !wb_we_i && wb_adr_i == OFS_IRQ_STAT
        |=> r_reg.irq_stat == $past(ev))
        else $error("interrupt status not cleared by read");
    ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge held longer than one cycle");

endmodule : urxs_top

//--- tb/urxs_tx_model.sv
// Behavioural far-end serial transmitter feeding the receive pin.
// Assumes the bench raises go_i for one cycle while busy_o is low.
`timescale 1ns/10ps
module urxs_tx_model
    import urxs_pkg::*;
(
    // Clock
    input  wire logic       clk_i,
    // Frame request
    input  wire logic       go_i,
    input  wire urxs_mode_t mode_i,
    input  wire logic [8:0] data_i,
    input  wire logic       bad_par_i,
    input  wire logic       bad_stop_i,
    // Line and status
    output logic            rxd_o,
    output logic            busy_o
);
    logic bits[$];
    logic par;
    int   n;

    // One frame per request, LSB first; line idles high between frames
    initial begin
        rxd_o  = 1'b1;
        busy_o = 1'b0;
        forever begin
            @(posedge clk_i);
            if (go_i === 1'b1) begin
                busy_o <= 1'b1;
                n    = (mode_i == URXS_MODE_9N) ? 9 : 8;
                par  = ^data_i[7:0] ^ (mode_i == URXS_MODE_8O) ^ bad_par_i;
                bits = {1'b0};
                for (int i = 0; i < n; i++) begin
                    bits.push_back(data_i[i]);
                end
                if (mode_i == URXS_MODE_8E || mode_i == URXS_MODE_8O) begin
                    bits.push_back(par);
                end
                bits.push_back(~bad_stop_i);
                // Guard bit keeps frames from running together
                bits.push_back(1'b1);
                foreach (bits[i]) begin
                    rxd_o <= bits[i];
                    repeat (BIT_CYCLES) @(posedge clk_i);
                end
                busy_o <= 1'b0;
            end
        end
    end
endmodule : urxs_tx_model

//--- tb/tb.sv
// Self-checking bench for the serial receive status block.
// Assumes the design answers each Wishbone request within a few cycles.
`timescale 1ns/10ps
module tb
    import urxs_pkg::*;
;
    localparam int CYCLE_LIMIT = 40000;

    logic        clk_i, rst_i, cyc, stb, we, tx_go, tx_bp, tx_bs, tx_busy;
    logic        rxd, irq_o, wb_ack_o;
    logic [7:0]  adr;
    logic [31:0] wdat, wb_dat_o, lfsr, r;
    logic [8:0]  tx_data;
    urxs_mode_t  m_mode;
    logic [10:0] q[$];
    logic        m_receive_overrun_flag, m_addr;
    logic [3:0]  m_irq, m_mask;
    int          n_mismatch, n_compared, cyc_cnt;

    urxs_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .rxd_i(rxd), .irq_o(irq_o));

    urxs_tx_model u_tx (.clk_i(clk_i), .go_i(tx_go), .mode_i(m_mode),
        .data_i(tx_data), .bad_par_i(tx_bp), .bad_stop_i(tx_bs),
        .rxd_o(rxd), .busy_o(tx_busy));

    // Clock and hang guard
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == CYCLE_LIMIT) begin
            n_mismatch++;
            conclude();
        end
    end

    function automatic logic [31:0] nxt(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : nxt

    // Expected status word from the model
    function automatic logic [31:0] exp_st(input logic idle);
        logic [10:0] h;
        h = (q.size() != 0) ? q[0] : 11'h000;
        return {26'h0, m_addr, idle, h[9], h[10], m_receive_overrun_flag, q.size() != 0};
    endfunction : exp_st

    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    // One classic cycle; released after ack is sampled high or after 20 cycles without ack
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] rd);
        int n;
        n = 0;
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        if (n >= 20) begin
            chk("ack", 32'h1, 32'h0);
        end
        @(posedge clk_i);
    endtask : xfer

    task automatic rd_chk(input string nm, input logic [7:0] a,
                          input logic [31:0] e);
        xfer(1'b0, a, 32'h0, r);
        chk(nm, e, r);
    endtask : rd_chk

    task automatic wr_st(input logic [31:0] d);
        xfer(1'b1, OFS_STATUS, d, r);
        m_addr = d[BIT_ADDRESS_DETECT_ENABLE];
        if (m_receive_overrun_flag && !d[BIT_RECEIVE_OVERRUN_FLAG]) begin
            m_receive_overrun_flag = 1'b0;
            q.delete();
        end
    endtask : wr_st

    task automatic set_cfg(input urxs_mode_t md, input logic [3:0] mk);
        m_mode <= md;
        xfer(1'b1, OFS_CONFIG, {30'h0, md}, r);
        xfer(1'b1, OFS_IRQ_MASK, {28'h0, mk}, r);
        m_mask = mk;
    endtask : set_cfg

    task automatic pop_chk;
        rd_chk("rx_data", OFS_RXDATA, q.size() ? {23'h0, q[0][8:0]} : 32'h0);
        if (q.size() != 0) begin
            void'(q.pop_front());
        end
    endtask : pop_chk

    task automatic irq_chk;
        chk("irq_o", {31'h0, |(m_irq & m_mask)}, {31'h0, irq_o});
    endtask : irq_chk

    // Send one frame and update the expected receive state
    task automatic send(input logic [8:0] d, input logic bp,
                        input logic bs, input logic peek);
        int         n;
        logic [8:0] v;
        logic       pe;
        n = 0;
        tx_data <= d;
        tx_bp   <= bp;
        tx_bs   <= bs;
        tx_go   <= 1'b1;
        @(posedge clk_i);
        tx_go <= 1'b0;
        if (peek) begin
            repeat (300) @(posedge clk_i);
            rd_chk("busy_status", OFS_STATUS, exp_st(1'b0));
        end
        do begin
            @(posedge clk_i);
            n++;
        end while (tx_busy === 1'b1 && n < 2000);
        repeat (8) @(posedge clk_i);
        v  = (m_mode == URXS_MODE_9N) ? d : {1'b0, d[7:0]};
        pe = bp && (m_mode == URXS_MODE_8E || m_mode == URXS_MODE_8O);
        if (m_receive_overrun_flag || (m_mode == URXS_MODE_9N && m_addr && !v[8])) begin
            return;
        end
        if (q.size() == FIFO_DEPTH) begin
            m_receive_overrun_flag   = 1'b1;
            m_irq[1] = 1'b1;
            return;
        end
        q.push_back({bs, pe, v});
        m_irq = m_irq | {bs, pe, 2'b01};
    endtask : send

    // Main sequence
    initial begin
        {clk_i, cyc, stb, we, tx_go, tx_bp, tx_bs} = '0;
        {m_receive_overrun_flag, m_addr, m_irq, m_mask, n_mismatch, n_compared} = '0;
        {adr, wdat, tx_data, cyc_cnt} = '0;
        m_mode = URXS_MODE_8N;
        rst_i  = 1'b1;
        lfsr   = 32'h0001_68F7;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd_chk("reset_status", OFS_STATUS, exp_st(1'b1));
        rd_chk("unmapped", 8'h14, 32'h0);
        // Every format, one clean and one damaged character each
        for (int m = 0; m < 4; m++) begin
            set_cfg(urxs_mode_t'(m), 4'b0001);
            for (int k = 0; k < 2; k++) begin
                lfsr = nxt(lfsr);
                send(lfsr[8:0], k == 1 && m inside {1, 2},
                     k == 1 && m != 1, k == 0);
                rd_chk("status", OFS_STATUS, exp_st(1'b1));
                irq_chk();
                pop_chk();
                rd_chk("empty", OFS_STATUS, exp_st(1'b1));
            end
            rd_chk("irq_stat", OFS_IRQ_STAT, {28'h0, m_irq});
            m_irq = 4'h0;
            irq_chk();
        end
        // Address detect only counts in the 9-bit format
        wr_st(32'h0000_0020);
        send(9'h0A5, 1'b0, 1'b0, 1'b0);
        rd_chk("non_addr", OFS_STATUS, exp_st(1'b1));
        send(9'h1C3, 1'b0, 1'b0, 1'b0);
        rd_chk("addr_char", OFS_STATUS, exp_st(1'b1));
        pop_chk();
        set_cfg(URXS_MODE_8N, 4'b0010);
        send(9'h05A, 1'b0, 1'b0, 1'b0);
        rd_chk("addr_8bit", OFS_STATUS, exp_st(1'b1));
        pop_chk();
        // Overrun: fill past depth, try to set, drop, then flush
        wr_st(32'h0000_0000);
        for (int i = 0; i <= FIFO_DEPTH; i++) begin
            lfsr = nxt(lfsr);
            send(lfsr[8:0], 1'b0, 1'b0, 1'b0);
        end
        rd_chk("overrun", OFS_STATUS, exp_st(1'b1));
        irq_chk();
        wr_st(32'h0000_0002);
        rd_chk("set_try", OFS_STATUS, exp_st(1'b1));
        send(9'h033, 1'b0, 1'b0, 1'b0);
        pop_chk();
        rd_chk("dropped", OFS_STATUS, exp_st(1'b1));
        wr_st(32'h0000_0000);
        rd_chk("flushed", OFS_STATUS, exp_st(1'b1));
        pop_chk();
        send(9'h0C9, 1'b0, 1'b0, 1'b0);
        rd_chk("after", OFS_STATUS, exp_st(1'b1));
        pop_chk();
        rd_chk("irq_stat", OFS_IRQ_STAT, {28'h0, m_irq});
        conclude();
    end
endmodule : tb
